// >>> hdl/dgsd_defs.vh
/*
 * register offsets, field positions, reset values, ramp divisors and
 * filter coefficients of the playback gain / soft mute / emphasis path.
 * assumes it is included by bare name; definitions only.
 */
`ifndef DGSD_DEFS_VH
`define DGSD_DEFS_VH

// register offsets
`define DGSD_OFS_POWER        8'h0b
`define DGSD_OFS_MUTE_EMPH    8'h1f
`define DGSD_OFS_GAIN         8'h1e

// field positions
`define DGSD_BIT_POWER_ON     0
`define DGSD_BIT_SPEED        10
`define DGSD_BIT_UNMUTE_RAMP  9
`define DGSD_BIT_SOFT_MUTE    3
`define DGSD_EMPH_HI          2
`define DGSD_EMPH_LO          1

// reset values
`define DGSD_RST_POWER_ON     1'h0
`define DGSD_RST_SOFT_MUTE    1'h1
`define DGSD_RST_UNMUTE_RAMP  1'h0
`define DGSD_RST_SPEED        1'h0
`define DGSD_RST_EMPH         2'h0
`define DGSD_RST_GAIN         8'hc0

// gain law
`define DGSD_VOL_UNITY        8'hc0
`define DGSD_VOL_MUTE         8'h00
`define DGSD_MANT_FRAC        15

// ramp divisors in samples, minus one
`define DGSD_RAMP_FAST_LIM    5'h01
`define DGSD_RAMP_SLOW_LIM    5'h1f

// emphasis curve codes
`define DGSD_EMPH_OFF         2'h0
`define DGSD_EMPH_32K         2'h1
`define DGSD_EMPH_44K1        2'h2
`define DGSD_EMPH_48K         2'h3

// first-order shelf, q14: y = b0*x - b1*x1 + a1*y1
`define DGSD_COEF_FRAC        14
`define DGSD_B0_32K           16'h21f9
`define DGSD_B1_32K           16'h043b
`define DGSD_A1_32K           16'h2242
`define DGSD_B0_44K1          16'h1def
`define DGSD_B1_44K1          16'h0699
`define DGSD_A1_44K1          16'h28aa
`define DGSD_B0_48K           16'h1d0f
`define DGSD_B1_48K           16'h073f
`define DGSD_A1_48K           16'h2a30

`endif

// >>> hdl/dgsd_fifo.v
/*
 * sample fifo with registered ready/valid on both sides.
 * assumes one clock, synchronous active-high reset, same-clock neighbours.
 */
`timescale 1ns/1ps
`default_nettype none

module dgsd_fifo #(
  parameter DATA_W = 24,
  parameter DEPTH  = 8,
  parameter ADDR_W = 3
) (
  input  wire              clk_i,
  input  wire              rst_i,
  input  wire [DATA_W-1:0] in_data_i,
  input  wire              in_valid_i,
  output reg               in_ready_o,
  output wire [DATA_W-1:0] out_data_o,
  output reg               out_valid_o,
  input  wire              out_ready_i
);

  reg  [DATA_W-1:0] mem [0:DEPTH-1];
  reg  [ADDR_W-1:0] wr_ptr;
  reg  [ADDR_W-1:0] rd_ptr;
  reg  [ADDR_W:0]   count;
  wire              push = in_valid_i & in_ready_o;
  wire              pop  = out_ready_i & out_valid_o;
  wire [ADDR_W:0]   next_count = count + {{ADDR_W{1'b0}}, push} - {{ADDR_W{1'b0}}, pop};
  wire [ADDR_W:0]   depth_w = DEPTH[ADDR_W:0];
  wire [ADDR_W-1:0] last_w  = DEPTH[ADDR_W-1:0] - 1'b1;

  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1) begin : g_entry
      localparam [ADDR_W-1:0] ENTRY_IDX = i;
      always @(posedge clk_i) begin
        if (push && (wr_ptr == ENTRY_IDX)) begin
          mem[i] <= in_data_i;
        end
      end
    end
  endgenerate

  assign out_data_o = mem[rd_ptr];

  always @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr      <= {ADDR_W{1'b0}};
      rd_ptr      <= {ADDR_W{1'b0}};
      count       <= {(ADDR_W+1){1'b0}};
      in_ready_o  <= 1'b0;
      out_valid_o <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == last_w) ? {ADDR_W{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == last_w) ? {ADDR_W{1'b0}} : rd_ptr + 1'b1;
      end
      count       <= next_count;
      in_ready_o  <= (next_count != depth_w);
      out_valid_o <= (next_count != {(ADDR_W+1){1'b0}});
    end
  end

endmodule

`default_nettype wire

// >>> hdl/dgsd_core.v
/*
 * playback digital front end: sample fifo, digital volume with soft mute
 * ramps, optional emphasis-removal shelf and 2x interpolation toward the
 * modulator. registers are written over a simple parallel control port.
 * assumes the sample source and the modulator run on ref_clk_i.
 */
// Overview of operation
// - playback runs only while the converter power bit is set; resets to off
// - digital volume spans -71.625 dB to 0 dB in 0.375 dB steps
// - code x in 1..192 gives 0.375*(x-192) dB gain
// - code 0 silences fully; code 1 gives -71.625 dB
// - codes 193..255 are reserved and act as 0 dB
// - soft mute ramps the gain down gradually
// - unmute with ramp select 0 restores volume at once
// - unmute with ramp select 1 ramps gain up to the volume
// - speed bit 0 steps every 2 samples, 1 every 32 samples
// - full ramp at 48 kHz within 10.7 ms fast, 171 ms slow
// - ramp time proportional to the gain distance travelled
// - ramp ticks come from samples, so speed scales with rate
// - curve select: 00 off, 01 32 kHz, 10 44.1 kHz, 11 48 kHz
// - samples pass 24-bit interpolation before the modulator
`timescale 1ns/1ps
`default_nettype none
`include "dgsd_defs.vh"

module dgsd_core #(
  parameter SAMPLE_W   = 24,
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW    = 3
) (
  input  wire                ref_clk_i,
  input  wire                rst_i,
  input  wire [7:0]          reg_addr_i,
  input  wire [15:0]         reg_wdata_i,
  input  wire                reg_wr_i,
  output reg  [15:0]         reg_rdata_o,
  input  wire [SAMPLE_W-1:0] playback_serial_input_i,
  input  wire                sample_valid_i,
  output wire                sample_ready_o,
  output reg  [SAMPLE_W-1:0] mod_data_o,
  output reg                 mod_valid_o,
  input  wire                mod_ready_i
);

  ////////////////////////////////////////////////////////////////////////////
  // control registers

  reg       converter_power_on;
  reg       soft_mute;
  reg       unmute_ramp_select;
  reg       ramp_speed_select;
  reg [1:0] emphasis_curve_select;
  reg [7:0] playback_gain_code;
  reg [7:0] eff_gain;

  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      converter_power_on    <= `DGSD_RST_POWER_ON;
      soft_mute             <= `DGSD_RST_SOFT_MUTE;
      unmute_ramp_select    <= `DGSD_RST_UNMUTE_RAMP;
      ramp_speed_select     <= `DGSD_RST_SPEED;
      emphasis_curve_select <= `DGSD_RST_EMPH;
      playback_gain_code    <= `DGSD_RST_GAIN;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `DGSD_OFS_POWER: begin
          converter_power_on <= reg_wdata_i[`DGSD_BIT_POWER_ON];
        end
        `DGSD_OFS_MUTE_EMPH: begin
          ramp_speed_select     <= reg_wdata_i[`DGSD_BIT_SPEED];
          unmute_ramp_select    <= reg_wdata_i[`DGSD_BIT_UNMUTE_RAMP];
          soft_mute             <= reg_wdata_i[`DGSD_BIT_SOFT_MUTE];
          emphasis_curve_select <= reg_wdata_i[`DGSD_EMPH_HI:`DGSD_EMPH_LO];
        end
        `DGSD_OFS_GAIN: begin
          playback_gain_code <= reg_wdata_i[7:0];
        end
        default: begin
        end
      endcase
    end
  end

  // read data one cycle after the address; unmapped offsets read zero
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= 16'h0000;
    end else begin
      case (reg_addr_i)
        `DGSD_OFS_POWER: begin
          reg_rdata_o <= {15'h0000, converter_power_on};
        end
        `DGSD_OFS_MUTE_EMPH: begin
          reg_rdata_o <= {5'h00, ramp_speed_select, unmute_ramp_select, 5'h00,
                          soft_mute, emphasis_curve_select, 1'b0};
        end
        `DGSD_OFS_GAIN: begin
          reg_rdata_o <= {eff_gain, playback_gain_code};
        end
        default: begin
          reg_rdata_o <= 16'h0000;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sample fifo

  wire [SAMPLE_W-1:0] fifo_data;
  wire                fifo_valid;
  wire                fifo_pop;

  dgsd_fifo #(
    .DATA_W (SAMPLE_W),
    .DEPTH  (FIFO_DEPTH),
    .ADDR_W (FIFO_AW)
  ) u_fifo (
    .clk_i       (ref_clk_i),
    .rst_i       (rst_i),
    .in_data_i   (playback_serial_input_i),
    .in_valid_i  (sample_valid_i),
    .in_ready_o  (sample_ready_o),
    .out_data_o  (fifo_data),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_pop)
  );

  ////////////////////////////////////////////////////////////////////////////
  // soft mute ramp

  localparam ST_IDLE = 3'h0;
  localparam ST_GAIN = 3'h1;
  localparam ST_EMPH = 3'h2;
  localparam ST_MID  = 3'h3;
  localparam ST_CUR  = 3'h4;

  reg  [2:0] state;
  reg  [4:0] ramp_cnt;
  reg        ramp_up;
  reg        soft_mute_d;

  assign fifo_pop = (state == ST_IDLE) & fifo_valid;

  // reserved codes clamp to unity
  wire [7:0] vol_target = (playback_gain_code > `DGSD_VOL_UNITY) ?
                          `DGSD_VOL_UNITY : playback_gain_code;
  wire [4:0] ramp_lim = ramp_speed_select ? `DGSD_RAMP_SLOW_LIM
                                          : `DGSD_RAMP_FAST_LIM;
  // one tick per ramp_lim+1 consumed samples
  wire       ramp_tick = fifo_pop & (ramp_cnt == ramp_lim);
  wire       unmute_edge = soft_mute_d & ~soft_mute;

  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      ramp_cnt <= 5'h00;
    end else if (fifo_pop) begin
      ramp_cnt <= (ramp_cnt >= ramp_lim) ? 5'h00 : ramp_cnt + 5'h01;
    end
  end

  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      eff_gain    <= `DGSD_VOL_MUTE;
      ramp_up     <= 1'b0;
      soft_mute_d <= `DGSD_RST_SOFT_MUTE;
    end else begin
      soft_mute_d <= soft_mute;
      if (soft_mute) begin
        ramp_up <= 1'b0;
        if (ramp_tick && (eff_gain != `DGSD_VOL_MUTE)) begin
          eff_gain <= eff_gain - 8'h01;
        end
      end else if (unmute_edge) begin
        if (unmute_ramp_select) begin
          ramp_up <= 1'b1;
        end else begin
          eff_gain <= vol_target;
        end
      end else if (ramp_up) begin
        if (eff_gain == vol_target) begin
          ramp_up <= 1'b0;
        end else if (ramp_tick) begin
          eff_gain <= (eff_gain < vol_target) ? eff_gain + 8'h01
                                              : eff_gain - 8'h01;
        end
      end else begin
        eff_gain <= vol_target;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // volume: 16 codes make 6 dB, so mantissa table plus a shift

  reg  signed [SAMPLE_W-1:0] x_in;
  reg  signed [SAMPLE_W-1:0] g_q;
  reg         [15:0]         mant;
  wire        [7:0]          atten = `DGSD_VOL_UNITY - eff_gain;

  always @* begin
    case (atten[3:0])
      4'h0: mant = 16'h8000;
      4'h1: mant = 16'h7a98;
      4'h2: mant = 16'h7569;
      4'h3: mant = 16'h7074;
      4'h4: mant = 16'h6bb3;
      4'h5: mant = 16'h6726;
      4'h6: mant = 16'h62ca;
      4'h7: mant = 16'h5e9d;
      4'h8: mant = 16'h5a9e;
      4'h9: mant = 16'h56ca;
      4'ha: mant = 16'h531f;
      4'hb: mant = 16'h4f9c;
      4'hc: mant = 16'h4c3f;
      4'hd: mant = 16'h4906;
      4'he: mant = 16'h45f0;
      4'hf: mant = 16'h42fc;
      default: mant = 16'h8000;
    endcase
  end

  wire signed [SAMPLE_W+16:0] gain_prod = x_in * $signed({1'b0, mant});
  wire signed [SAMPLE_W+16:0] gain_sh   = gain_prod >>> (`DGSD_MANT_FRAC + atten[7:4]);
  wire signed [SAMPLE_W-1:0]  gain_out  = (eff_gain == `DGSD_VOL_MUTE) ?
                                          {SAMPLE_W{1'b0}} : gain_sh[SAMPLE_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // emphasis removal shelf

  reg         [15:0]         c_b0;
  reg         [15:0]         c_b1;
  reg         [15:0]         c_a1;
  reg  signed [SAMPLE_W-1:0] x1;
  reg  signed [SAMPLE_W-1:0] y1;

  always @* begin
    case (emphasis_curve_select)
      `DGSD_EMPH_32K: begin
        c_b0 = `DGSD_B0_32K;
        c_b1 = `DGSD_B1_32K;
        c_a1 = `DGSD_A1_32K;
      end
      `DGSD_EMPH_44K1: begin
        c_b0 = `DGSD_B0_44K1;
        c_b1 = `DGSD_B1_44K1;
        c_a1 = `DGSD_A1_44K1;
      end
      `DGSD_EMPH_48K: begin
        c_b0 = `DGSD_B0_48K;
        c_b1 = `DGSD_B1_48K;
        c_a1 = `DGSD_A1_48K;
      end
      default: begin
        c_b0 = 16'h0000;
        c_b1 = 16'h0000;
        c_a1 = 16'h0000;
      end
    endcase
  end

  wire signed [SAMPLE_W+16:0] p_b0 = g_q * $signed({1'b0, c_b0});
  wire signed [SAMPLE_W+16:0] p_b1 = x1  * $signed({1'b0, c_b1});
  wire signed [SAMPLE_W+16:0] p_a1 = y1  * $signed({1'b0, c_a1});
  wire signed [SAMPLE_W+17:0] iir_acc = {p_b0[SAMPLE_W+16], p_b0}
                                      - {p_b1[SAMPLE_W+16], p_b1}
                                      + {p_a1[SAMPLE_W+16], p_a1};
  wire signed [SAMPLE_W+17:0] iir_sh = iir_acc >>> `DGSD_COEF_FRAC;
  // curve off passes the gained sample untouched
  wire signed [SAMPLE_W-1:0]  y_new = (emphasis_curve_select == `DGSD_EMPH_OFF) ?
                                      g_q : iir_sh[SAMPLE_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // 2x interpolation and modulator handshake

  reg  signed [SAMPLE_W-1:0] prev_out;
  reg  signed [SAMPLE_W-1:0] cur_out;
  wire signed [SAMPLE_W:0]   mid_sum = {prev_out[SAMPLE_W-1], prev_out}
                                     + {y_new[SAMPLE_W-1], y_new};

  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      state       <= ST_IDLE;
      x_in        <= {SAMPLE_W{1'b0}};
      g_q         <= {SAMPLE_W{1'b0}};
      x1          <= {SAMPLE_W{1'b0}};
      y1          <= {SAMPLE_W{1'b0}};
      prev_out    <= {SAMPLE_W{1'b0}};
      cur_out     <= {SAMPLE_W{1'b0}};
      mod_data_o  <= {SAMPLE_W{1'b0}};
      mod_valid_o <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (fifo_pop) begin
            if (converter_power_on) begin
              x_in  <= fifo_data;
              state <= ST_GAIN;
            end else begin
              // disabled: samples drop, history clears
              x1       <= {SAMPLE_W{1'b0}};
              y1       <= {SAMPLE_W{1'b0}};
              prev_out <= {SAMPLE_W{1'b0}};
            end
          end
        end
        ST_GAIN: begin
          g_q   <= gain_out;
          state <= ST_EMPH;
        end
        ST_EMPH: begin
          x1          <= g_q;
          y1          <= y_new;
          prev_out    <= y_new;
          cur_out     <= y_new;
          mod_data_o  <= mid_sum[SAMPLE_W:1];
          mod_valid_o <= 1'b1;
          state       <= ST_MID;
        end
        ST_MID: begin
          if (mod_ready_i) begin
            mod_data_o <= cur_out;
            state      <= ST_CUR;
          end
        end
        ST_CUR: begin
          if (mod_ready_i) begin
            mod_valid_o <= 1'b0;
            state       <= ST_IDLE;
          end
        end
        default: begin
          mod_valid_o <= 1'b0;
          state       <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// >>> verif/dgsd_monitor.sv
/* port checker for the playback gain, soft mute and emphasis block.
   assumes one clock, synchronous reset, attached by the bind at the foot. */
`timescale 1ns/1ps
`default_nettype none

module dgsd_monitor #(
  parameter int SAMPLE_W = 24
) (
  input wire logic                ref_clk_i,
  input wire logic                rst_i,
  input wire logic [7:0]          reg_addr_i,
  input wire logic [15:0]         reg_wdata_i,
  input wire logic                reg_wr_i,
  input wire logic [15:0]         reg_rdata_o,
  input wire logic                sample_ready_o,
  input wire logic [SAMPLE_W-1:0] mod_data_o,
  input wire logic                mod_valid_o,
  input wire logic                mod_ready_i
);
  logic       pwr, was_on, spd, ur, sm;
  logic [1:0] emph;
  logic [7:0] code;
  logic [2:0] quiet;
  wire  [7:0] eff = reg_rdata_o[15:8];

  //////////////////////////////
  // register shadow, soft mute resets set
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      {pwr, was_on, spd, ur, sm, emph} <= 7'h04;
      code  <= 8'hc0;
      quiet <= 3'h0;
    end else begin
      quiet <= reg_wr_i ? 3'h0 : quiet + {2'h0, quiet != 3'h7};
      if (reg_wr_i && reg_addr_i == 8'h0b) begin
        pwr    <= reg_wdata_i[0];
        was_on <= was_on | reg_wdata_i[0];
      end
      if (reg_wr_i && reg_addr_i == 8'h1f)
        {spd, ur, sm, emph} <= {reg_wdata_i[10:9], reg_wdata_i[3:1]};
      if (reg_wr_i && reg_addr_i == 8'h1e)
        code <= reg_wdata_i[7:0];
    end
  end

  //////////////////////////////
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  a_reset_quiet: assert property (
    $past(rst_i) |-> !mod_valid_o && !sample_ready_o && reg_rdata_o == 16'h0000)
    else $error("outputs not quiet after reset");
  a_hold_output: assert property (
    mod_valid_o && !mod_ready_i |=> mod_valid_o && $stable(mod_data_o))
    else $error("output word dropped or changed while stalled");
  a_no_play_off: assert property (
    !was_on |-> !mod_valid_o)
    else $error("output produced before power on");
  a_power_readback: assert property (
    $past(reg_addr_i) == 8'h0b && !$past(reg_wr_i) && !$past(rst_i) |-> reg_rdata_o == {15'h0000, pwr})
    else $error("power register readback wrong");
  a_ctrl_readback: assert property (
    $past(reg_addr_i) == 8'h1f && !$past(reg_wr_i) && !$past(rst_i)
    |-> reg_rdata_o == {5'h00, spd, ur, 5'h00, sm, emph, 1'b0})
    else $error("mute control readback wrong");
  a_gain_readback: assert property (
    $past(reg_addr_i) == 8'h1e && !$past(reg_wr_i) && !$past(rst_i) |-> reg_rdata_o[7:0] == code)
    else $error("gain code readback wrong");
  a_unmute_now: assert property (
    $past(reg_addr_i) == 8'h1e && quiet >= 3'h3 && !sm && !ur && code <= 8'hc0 |-> eff == code)
    else $error("gain not restored at once");
  a_mute_down: assert property (
    $past(reg_addr_i) == 8'h1e && $past(reg_addr_i, 2) == 8'h1e && quiet >= 3'h3 && sm
    |-> eff == $past(eff) || eff == $past(eff) - 8'h01)
    else $error("mute ramp step wrong");
  a_ramp_up: assert property (
    $past(reg_addr_i) == 8'h1e && $past(reg_addr_i, 2) == 8'h1e && quiet >= 3'h3 && !sm && ur
    |-> eff == $past(eff) || eff == $past(eff) + 8'h01)
    else $error("unmute ramp step wrong");

  c_fifo_full: cover property (!sample_ready_o && !mod_ready_i && mod_valid_o);
  c_mute_ramp: cover property ($past(reg_addr_i) == 8'h1e && sm && eff == 8'h01);
  c_ramp_up:   cover property ($past(reg_addr_i) == 8'h1e && !sm && ur && eff != code);
endmodule

bind dgsd_core dgsd_monitor #(.SAMPLE_W(SAMPLE_W)) u_monitor (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rdata_o(reg_rdata_o), .sample_ready_o(sample_ready_o),
  .mod_data_o(mod_data_o), .mod_valid_o(mod_valid_o), .mod_ready_i(mod_ready_i));

`default_nettype wire

// >>> verif/dgsd_src.sv
/* audio receiver model feeding sample words over valid/ready.
   assumes the block's clock and reset; ready is sampled at the rising edge. */
`timescale 1ns/1ps
`default_nettype none

module dgsd_src (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        run_i,
  input  wire logic        slow_i,
  input  wire logic [23:0] word_i,
  input  wire logic        ready_i,
  output logic             valid_o,
  output logic [23:0]      data_o,
  output logic [15:0]      sent_o
);
  // word held until taken; idle lines toggle each cycle between the last word and its inverse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      valid_o <= 1'b0;
      data_o  <= 24'h00_0000;
      sent_o  <= 16'h0000;
    end else if (!valid_o || ready_i) begin
      sent_o  <= sent_o + {15'h0000, valid_o};
      valid_o <= run_i && !(slow_i && valid_o);
      data_o  <= (run_i && !(slow_i && valid_o)) ? word_i : ~data_o;
    end
  end
endmodule

`default_nettype wire

// >>> verif/testbench.sv
/* self-checking bench for dgsd_core with the sample source model.
   assumes dgsd_core, dgsd_src and the checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic        ref_clk_i   = 1'b0;
  logic        rst_i       = 1'b1;
  logic [7:0]  reg_addr_i  = 8'h00;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic        reg_wr_i    = 1'b0;
  logic        mod_ready_i = 1'b1;
  logic        run         = 1'b0;
  logic        slow        = 1'b0;
  wire  [15:0] reg_rdata_o, sent;
  wire  [23:0] smp, mod_data_o;
  wire         smp_valid, sample_ready_o, mod_valid_o;
  logic [23:0] rd_val;
  logic [15:0] mark;
  int          d;
  int          n_errors    = 0;
  int          checks_done = 0;
  logic [7:0]  codes [4]   = '{8'hc0, 8'hb0, 8'h01, 8'hff};
  logic [23:0] levels [4]  = '{24'h40_0000, 24'h20_0000, 24'h00_044c, 24'h40_0000};

  always #20 ref_clk_i = ~ref_clk_i;

  dgsd_core dut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rdata_o(reg_rdata_o), .playback_serial_input_i(smp),
    .sample_valid_i(smp_valid), .sample_ready_o(sample_ready_o), .mod_data_o(mod_data_o),
    .mod_valid_o(mod_valid_o), .mod_ready_i(mod_ready_i));
  dgsd_src src (
    .clk_i(ref_clk_i), .rst_i(rst_i), .run_i(run), .slow_i(slow), .word_i(24'h40_0000),
    .ready_i(sample_ready_o), .valid_o(smp_valid), .data_o(smp), .sent_o(sent));

  //////////////////////////////
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge ref_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= v;
    reg_wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    @(posedge ref_clk_i);
    #1 rd_val = {8'h00, reg_rdata_o};
  endtask
  // settled output of a constant stream, within 0x100
  task automatic level(input logic [23:0] exp);
    repeat (120) @(posedge ref_clk_i);
    #1 chk(((mod_data_o - exp + 24'h00_0100) < 24'h00_0200) ? exp : mod_data_o, exp);
  endtask
  // follows the gain readback to tgt and judges the samples spent
  task automatic ramp_to(input logic [7:0] tgt, input int lo, input int hi);
    mark = sent;
    rd(8'h1e);
    for (int i = 0; i < 3000 && rd_val[15:8] !== tgt; i++)
      rd(8'h1e);
    d = int'(sent - mark);
    chk({16'h0000, rd_val[15:8]}, {16'h0000, tgt});
    chk({23'h0, d >= lo && d <= hi}, 24'h00_0001);
  endtask

  //////////////////////////////
  task automatic t_reset_values();
    rd(8'h0b);
    chk(rd_val, 24'h00_0000);
    rd(8'h1f);
    chk(rd_val, 24'h00_0008);
    rd(8'h1e);
    chk(rd_val, 24'h00_00c0);
    rd(8'h20);
    chk(rd_val, 24'h00_0000);
  endtask
  task automatic t_power_off();
    @(posedge ref_clk_i);
    run <= 1'b1;
    repeat (40) @(posedge ref_clk_i);
    #1 chk({23'h0, mod_valid_o}, 24'h00_0000);
    chk({23'h0, sent > 16'h0008}, 24'h00_0001);
  endtask
  task automatic t_gain_law();
    wr(8'h1f, 16'h0000);
    wr(8'h0b, 16'h0001);
    for (int i = 0; i < 4; i++) begin
      wr(8'h1e, {8'h00, codes[i]});
      level(levels[i]);
    end
    wr(8'h1e, 16'h0000);
    repeat (120) @(posedge ref_clk_i);
    #1 chk(mod_data_o, 24'h00_0000);
  endtask
  task automatic t_soft_mute();
    wr(8'h1e, 16'h0010);
    wr(8'h1f, 16'h0008);
    ramp_to(8'h00, 29, 36);
    wr(8'h1e, 16'h0008);
    wr(8'h1f, 16'h0000);
    rd(8'h1e);
    chk(rd_val, 24'h00_0808);
    @(posedge ref_clk_i);
    slow <= 1'b1;
    wr(8'h1f, 16'h0408);
    ramp_to(8'h00, 220, 262);
    wr(8'h1f, 16'h0200);
    rd(8'h1e);
    chk({23'h0, rd_val[15:8] < 8'h02}, 24'h00_0001);
    ramp_to(8'h08, 12, 20);
    @(posedge ref_clk_i);
    slow <= 1'b0;
  endtask
  task automatic t_emphasis();
    wr(8'h1e, 16'h00c0);
    for (int c = 0; c < 4; c++) begin
      wr(8'h1f, {13'h0000, c[1:0], 1'b0});
      rd(8'h1f);
      chk(rd_val, {21'h00_0000, c[1:0], 1'b0});
      level(24'h40_0000);
    end
  endtask
  task automatic t_fifo();
    @(posedge ref_clk_i);
    run <= 1'b0;
    repeat (60) @(posedge ref_clk_i);
    mod_ready_i <= 1'b0;
    run         <= 1'b1;
    mark = sent;
    repeat (40) @(posedge ref_clk_i);
    d = int'(sent - mark);
    #1 chk({23'h0, sample_ready_o}, 24'h00_0000);
    chk({23'h0, d >= 8 && d <= 11}, 24'h00_0001);
    @(posedge ref_clk_i);
    run         <= 1'b0;
    mod_ready_i <= 1'b1;
    repeat (80) @(posedge ref_clk_i);
    #1 chk({22'h0, sample_ready_o, mod_valid_o}, 24'h00_0002);
  endtask
  task automatic t_second_reset();
    @(posedge ref_clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rd(8'h1f);
    chk(rd_val, 24'h00_0008);
  endtask

  //////////////////////////////
  task automatic complete_run();
    $display("errors=%0d checks=%0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk_i);
    n_errors++;
    complete_run();
  end

  initial begin
    repeat (6) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    t_reset_values();
    t_power_off();
    t_gain_law();
    t_soft_mute();
    t_emphasis();
    t_fifo();
    t_second_reset();
    complete_run();
  end
endmodule

`default_nettype wire
